// File: hw/mac_rx_filter_pkg.sv
/*
 constants for the receive address filter, counters, wake and tx stamp.
 assumes a single 125 MHz clock domain and frame-level status inputs.
*/
// Operation
// - unicast passes on perfect match
// - unicast hash mode passes on hash hit
// - hash-or-perfect passes on either match
// - destination invert rejects matching unicast
// - multicast perfect match passes, pause dropped when control frame pass is 0 or 1
// - multicast hash or combined match passes
// - destination invert rejects matching multicast
// - source check reported, drops only with source discard
// - source discard drops failing frames
// - source invert fails matches without dropping
// - loopback bit, cleared after reset
// - rx counters only for passed or runt frames
// - tx good needs no tx errors
// - rx good needs no rx errors except gigabit align and type-frame length
// - size limit 1518 untagged, 1522 tagged
// - wake frame and magic detect, interrupt
// - power-down discards every frame
// - leave power-down only on enabled wake
// - magic checked only for own/multicast
// - stop mode wake needs external line
// - tx stamp at sfd when requested
// - stamp low word two, high three
// - broadcast passes unless blocked
// - four station addresses, 48-bit compare
// - control frame pass field governs pause
package mac_rx_filter_pkg;
   localparam int          MAC_W        = 48;
   localparam int          HASH_BITS    = 6;
   localparam int          HASH_SIZE    = 64;
   localparam int          LEN_W        = 16;
   localparam int          TS_W         = 64;
   localparam int          WORD_W       = 32;
   localparam int          STATIONS     = 4;
   localparam logic [15:0] RUNT_LIMIT   = 16'h0006;
   localparam logic [15:0] MIN_FRAME    = 16'h0040;
   localparam logic [15:0] MAX_UNTAGGED = 16'h05ee;
   localparam logic [15:0] MAX_TAGGED   = 16'h05f2;
   localparam logic [31:0] CRC_POLY     = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT     = 32'hffffffff;
   localparam logic [1:0]  CFP_PASS_ALL = 2'h2;
   localparam logic [1:0]  CFP_FILTER   = 2'h3;
   localparam int          TS_STEP_NS   = 8;
endpackage

// File: hw/eth_mac_rx_filter_pmt_mmc.sv
/*
 receive address filter with counter gating, power-down wake detect,
 loopback control and transmit timestamp capture.
 assumes frame status arrives as one-cycle strobes with fields valid.
*/
`timescale 1ns/1ps
module eth_mac_rx_filter_pmt_mmc #(
   parameter int N_STATION = mac_rx_filter_pkg::STATIONS,
   parameter int CNT_W     = 32
) (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   // filter configuration
   input  wire logic                      promiscuous_mode,
   input  wire logic                      unicast_hash_mode,
   input  wire logic                      multicast_hash_mode,
   input  wire logic                      dest_filter_invert,
   input  wire logic                      pass_all_multicast,
   input  wire logic                      broadcast_block,
   input  wire logic                      hash_or_perfect_mode,
   input  wire logic                      source_filter_invert,
   input  wire logic                      source_filter_discard,
   input  wire logic [1:0]                control_frame_pass,
   input  wire logic                      loopback_select,
   input  wire logic [63:0]               hash_table,
   input  wire logic [N_STATION*48-1:0]   station_addr,
   input  wire logic [N_STATION-1:0]      station_en,
   input  wire logic [N_STATION-1:0]      station_is_source,
   // received frame status
   input  wire logic                      rx_end,
   input  wire logic [47:0]               rx_dest,
   input  wire logic [47:0]               rx_src,
   input  wire logic [15:0]               rx_len,
   input  wire logic                      rx_pause,
   input  wire logic                      rx_vlan,
   input  wire logic                      rx_type_frame,
   input  wire logic                      rx_crc_err,
   input  wire logic                      rx_mii_err,
   input  wire logic                      rx_align_err,
   input  wire logic                      rx_len_err,
   input  wire logic                      rx_gigabit,
   input  wire logic                      rx_wake_frame,
   input  wire logic                      rx_magic,
   // power management
   input  wire logic                      power_down_req,
   input  wire logic                      wake_frame_detect_en,
   input  wire logic                      magic_packet_detect_en,
   input  wire logic                      stop_mode,
   input  wire logic                      external_interrupt_line,
   // transmit status
   input  wire logic                      tx_end,
   input  wire logic                      tx_underrun,
   input  wire logic                      tx_carrier_lost,
   input  wire logic                      tx_jabber,
   input  wire logic                      tx_late_coll,
   input  wire logic                      tx_exc_defer,
   input  wire logic                      tx_exc_coll,
   input  wire logic                      tx_sfd,
   input  wire logic                      tx_ts_request,
   // filter results
   output logic                           rx_result_valid,
   output logic                           rx_pass,
   output logic                           rx_da_fail,
   output logic                           rx_sa_fail,
   output logic                           rx_good,
   output logic                           rx_count_update,
   output logic                           loop_frame,
   output logic                           loopback_active,
   // counters
   output logic [CNT_W-1:0]               rx_frame_count,
   output logic [CNT_W-1:0]               rx_good_count,
   output logic [CNT_W-1:0]               tx_good_count,
   // power management status
   output logic                           power_down,
   output logic                           wake_irq,
   // transmit stamp
   output logic                           tx_ts_valid,
   output logic [31:0]                    tx_desc_word_two,
   output logic [31:0]                    tx_desc_word_three
);

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   generate
      if (N_STATION < 1 || CNT_W < 1) begin : g_bad
         $error("station count and counter width must be positive");
      end
   endgenerate

   // ------------------------------------------------------------
   // hash index: upper crc bits of the destination
   // ------------------------------------------------------------
   function automatic logic [5:0] hash_index(input logic [47:0] a);
      logic [31:0] c;
      c = mac_rx_filter_pkg::CRC_INIT;
      for (int i = 0; i < mac_rx_filter_pkg::MAC_W; i++) begin
         if (c[31] ^ a[i]) begin
            c = {c[30:0], 1'b0} ^ mac_rx_filter_pkg::CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      return c[31:26];
   endfunction

   // ------------------------------------------------------------
   // address compare
   // ------------------------------------------------------------
   logic [N_STATION-1:0] da_hit_v;
   logic [N_STATION-1:0] sa_hit_v;

   genvar g;
   generate
      for (g = 0; g < N_STATION; g++) begin : g_st
         // full 48-bit compare per entry
         assign da_hit_v[g] = station_en[g] && !station_is_source[g]
                              && station_addr[g*48 +: 48] == rx_dest;
         assign sa_hit_v[g] = station_en[g] && station_is_source[g]
                              && station_addr[g*48 +: 48] == rx_src;
      end
   endgenerate

   logic is_bcast;
   logic is_mcast;
   logic perf_hit;
   logic hash_hit;
   logic sa_match;

   assign is_bcast = &rx_dest;
   assign is_mcast = rx_dest[0] && !is_bcast;
   assign perf_hit = |da_hit_v;
   assign hash_hit = hash_table[hash_index(rx_dest)];
   assign sa_match = |sa_hit_v;

   // ------------------------------------------------------------
   // destination decision
   // ------------------------------------------------------------
   logic uc_sel;
   logic mc_sel;
   logic da_ok;
   logic pause_drop;

   always_comb begin
      // hash, perfect or either
      if (unicast_hash_mode) begin
         uc_sel = hash_or_perfect_mode ? (hash_hit || perf_hit) : hash_hit;
      end else begin
         uc_sel = perf_hit;
      end
      // same choice for groups
      if (multicast_hash_mode) begin
         mc_sel = hash_or_perfect_mode ? (hash_hit || perf_hit) : hash_hit;
      end else begin
         mc_sel = perf_hit;
      end
      if (promiscuous_mode) begin
         da_ok = 1'b1;
      end else if (is_bcast) begin
         da_ok = !broadcast_block;
      end else if (is_mcast) begin
         // invert flips group result
         da_ok = pass_all_multicast || (mc_sel ^ dest_filter_invert);
      end else begin
         da_ok = uc_sel ^ dest_filter_invert;
      end
   end

   // pause frames by control field
   assign pause_drop = rx_pause && !promiscuous_mode
                       && control_frame_pass != mac_rx_filter_pkg::CFP_FILTER
                       && control_frame_pass != mac_rx_filter_pkg::CFP_PASS_ALL;

   // ------------------------------------------------------------
   // source decision
   // ------------------------------------------------------------
   logic sa_ok;
   logic sa_drop;
   logic da_pass;
   logic pass_c;

   // invert turns match into failure
   assign sa_ok   = promiscuous_mode || (sa_match ^ source_filter_invert);
   // only non-inverted discard drops
   assign sa_drop = !sa_ok && source_filter_discard && !source_filter_invert;
   assign da_pass = (da_ok && !pause_drop)
                    || (rx_pause && control_frame_pass ==
                        mac_rx_filter_pkg::CFP_PASS_ALL);
   // nothing forwarded while powered down
   assign pass_c  = !power_down && da_pass && !sa_drop;

   // ------------------------------------------------------------
   // good frame checks
   // ------------------------------------------------------------
   logic [15:0] max_len;
   logic        rx_good_c;
   logic        runt;
   logic        tx_good_c;

   // tagged frames may be four bytes longer
   assign max_len   = rx_vlan ? mac_rx_filter_pkg::MAX_TAGGED
                              : mac_rx_filter_pkg::MAX_UNTAGGED;
   // length error and max size checks skip type frames
   assign rx_good_c = rx_len >= mac_rx_filter_pkg::MIN_FRAME
                      && !rx_crc_err && !rx_mii_err
                      && !(rx_align_err && !rx_gigabit)
                      && !(!rx_type_frame && (rx_len_err || rx_len > max_len));
   assign runt      = rx_len < mac_rx_filter_pkg::RUNT_LIMIT;
   assign tx_good_c = !(tx_underrun || tx_carrier_lost || tx_jabber
                      || tx_late_coll || tx_exc_defer || tx_exc_coll);

   // ------------------------------------------------------------
   // result register
   // ------------------------------------------------------------
   logic upd_c;
   // runts below six bytes still count
   assign upd_c = !power_down && (pass_c || runt);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_result_valid <= 1'b0;
         rx_pass         <= 1'b0;
         rx_da_fail      <= 1'b0;
         rx_sa_fail      <= 1'b0;
         rx_good         <= 1'b0;
         rx_count_update <= 1'b0;
         loop_frame      <= 1'b0;
      end else begin
         rx_result_valid <= rx_end;
         rx_pass         <= rx_end && pass_c;
         rx_da_fail      <= rx_end && !da_ok;
         rx_sa_fail      <= rx_end && !sa_ok;
         rx_good         <= rx_end && rx_good_c;
         rx_count_update <= rx_end && upd_c;
         loop_frame      <= rx_end && pass_c && loopback_active;
      end
   end

   // loopback disabled after reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loopback_active <= 1'b0;
      end else begin
         loopback_active <= loopback_select;
      end
   end

   // ------------------------------------------------------------
   // management counters
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_frame_count <= '0;
         rx_good_count  <= '0;
         tx_good_count  <= '0;
      end else begin
         if (rx_end && upd_c) begin
            rx_frame_count <= rx_frame_count + 1'b1;
         end
         if (rx_end && upd_c && rx_good_c) begin
            rx_good_count <= rx_good_count + 1'b1;
         end
         if (tx_end && tx_good_c) begin
            tx_good_count <= tx_good_count + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // power-down and wake
   // ------------------------------------------------------------
   logic wake_c;
   logic magic_ok;

   // magic only for own or group address
   assign magic_ok = magic_packet_detect_en && rx_magic
                     && (perf_hit || is_mcast);
   // stop mode needs the external line
   assign wake_c   = rx_end && power_down
                     && ((wake_frame_detect_en && rx_wake_frame) || magic_ok)
                     && (!stop_mode || external_interrupt_line);

   // wake beats a fresh entry request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         power_down <= 1'b0;
         wake_irq   <= 1'b0;
      end else begin
         wake_irq <= wake_c;
         if (wake_c) begin
            power_down <= 1'b0;
         end else if (power_down_req) begin
            power_down <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // timestamp counter and transmit capture
   // ------------------------------------------------------------
   localparam logic [63:0] TS_STEP = 64'(mac_rx_filter_pkg::TS_STEP_NS);
   logic [63:0] sys_time;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sys_time <= '0;
      end else begin
         sys_time <= sys_time + TS_STEP;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_ts_valid        <= 1'b0;
         tx_desc_word_two   <= '0;
         tx_desc_word_three <= '0;
      end else begin
         tx_ts_valid <= tx_sfd && tx_ts_request;
         if (tx_sfd && tx_ts_request) begin
            tx_desc_word_two   <= sys_time[31:0];
            tx_desc_word_three <= sys_time[63:32];
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_pd_discard;
      @(posedge ref_clk) disable iff (rst)
      rx_end && power_down |=> !rx_pass && !loop_frame;
   endproperty
   a_pd_discard: assert property (p_pd_discard)
      else $error("frame passed in power-down");

   property p_promisc;
      @(posedge ref_clk) disable iff (rst)
      rx_end && promiscuous_mode && !power_down |=> rx_pass;
   endproperty
   a_promisc: assert property (p_promisc)
      else $error("promiscuous frame dropped");

   property p_bcast_block;
      @(posedge ref_clk) disable iff (rst)
      rx_end && is_bcast && broadcast_block && !promiscuous_mode
      |=> !rx_pass && rx_da_fail;
   endproperty
   a_bcast_block: assert property (p_bcast_block)
      else $error("blocked broadcast passed");

   property p_sa_discard;
      @(posedge ref_clk) disable iff (rst)
      rx_end && !promiscuous_mode && source_filter_discard
      && !source_filter_invert && !sa_match |=> !rx_pass && rx_sa_fail;
   endproperty
   a_sa_discard: assert property (p_sa_discard)
      else $error("source failure not discarded");

   property p_runt_count;
      @(posedge ref_clk) disable iff (rst)
      rx_end && !power_down && runt
      |=> rx_count_update && rx_frame_count == $past(rx_frame_count) + 1'b1;
   endproperty
   a_runt_count: assert property (p_runt_count)
      else $error("runt frame not counted");

   property p_tx_bad;
      @(posedge ref_clk) disable iff (rst)
      tx_end && (tx_underrun || tx_jabber) |=> $stable(tx_good_count);
   endproperty
   a_tx_bad: assert property (p_tx_bad)
      else $error("errored tx frame counted good");

   property p_wake_exit;
      @(posedge ref_clk) disable iff (rst)
      power_down && !(rx_end && (rx_wake_frame || rx_magic))
      |=> power_down;
   endproperty
   a_wake_exit: assert property (p_wake_exit)
      else $error("power-down left without wake frame");

   property p_ts_capture;
      @(posedge ref_clk) disable iff (rst)
      tx_sfd && tx_ts_request
      |=> tx_ts_valid && tx_desc_word_two == $past(sys_time[31:0]);
   endproperty
   a_ts_capture: assert property (p_ts_capture)
      else $error("transmit stamp not captured");

   property p_loop_off;
      @(posedge ref_clk) disable iff (rst)
      !loopback_select ##1 rx_end |=> !loop_frame;
   endproperty
   a_loop_off: assert property (p_loop_off)
      else $error("loopback while disabled");

endmodule

// File: bench/phy_status_model.sv
/*
 far-side model: frame status source standing in for the phy receive path.
 assumes the bench calls send() and samples results one edge after rx_end.
*/
`timescale 1ns/1ps
module phy_status_model (
   // clock
   input  wire logic        ref_clk,
   // frame status
   output logic             rx_end,
   output logic [47:0]      rx_dest,
   output logic [47:0]      rx_src,
   output logic [15:0]      rx_len,
   output logic [9:0]       rx_flags
);
   // ----------------------------------------
   // status delivery
   // ----------------------------------------
   initial begin
      rx_end = 1'b0;
      rx_dest = 48'h0;
      rx_src = 48'h0;
      rx_len = 16'h0;
      rx_flags = 10'h0;
   end

   // still delivers status in power-down: receiver kept enabled
   task automatic send(input logic [47:0] d, s, input logic [15:0] l,
                       input logic [9:0] f);
      @(posedge ref_clk);
      #1;
      rx_end = 1'b1;
      rx_dest = d;
      rx_src = s;
      rx_len = l;
      rx_flags = f;
      @(posedge ref_clk);
      #1;
      rx_end = 1'b0;
      // stale fields inverted so nothing leans on last value
      rx_dest = ~rx_dest;
      rx_src = ~rx_src;
      rx_len = ~rx_len;
      rx_flags = ~rx_flags;
   endtask
endmodule

// File: bench/eth_mac_rx_filter_pmt_mmc_test.sv
/*
 bench for the receive filter: filter table, counters, power-down wake,
 tx good count and tx stamp. assumes phy_status_model drives rx status.
*/
`timescale 1ns/1ps
`define check(name, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value %s exp %0h got %0h", name, exp, got); \
   end \
end
module eth_mac_rx_filter_pmt_mmc_test;
   // ----------------------------------------
   // stimulus and expectations
   // ----------------------------------------
   localparam logic [47:0] UA = 48'h0a0b0c0d0e56;
   localparam logic [47:0] UO = 48'h0a0b0c0d0e58;
   localparam logic [47:0] UH = 48'h8a0b0c0d0e56;
   localparam logic [47:0] MA = 48'h0a0b0c0d0e01;
   localparam logic [47:0] MO = 48'h0a0b0c0d0e03;
   localparam logic [47:0] SA = 48'h0a0b0c0d0ea0;
   localparam logic [47:0] SO = 48'h0a0b0c0d0ea2;
   localparam logic [47:0] D3 = 48'h0a0b0c0d0e70;
   localparam logic [47:0] BC = 48'hffffffffffff;
   localparam logic [15:0] N  = 16'h0064;
   localparam logic [11:0] C0 = 12'h000, AL = 12'h800, UHS = 12'h400;
   localparam logic [11:0] MHS = 12'h200, DINV = 12'h100, AM = 12'h080;
   localparam logic [11:0] BBLK = 12'h040, HOP = 12'h020, SINV = 12'h010;
   localparam logic [11:0] SDISC = 12'h008, CF2 = 12'h002, CF3 = 12'h003;
   localparam logic [9:0]  F0 = 10'h000, P = 10'h200, V = 10'h100;
   localparam logic [9:0]  T = 10'h080, C = 10'h040, M = 10'h020;
   localparam logic [9:0]  A = 10'h010, L = 10'h008, G = 10'h004;
   localparam logic [9:0]  W = 10'h002, K = 10'h001;

   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic [11:0]       cfg = 12'h000;
   logic [63:0]       hash_table = 64'h0;
   logic              loopback_select = 1'b0;
   logic              power_down_req = 1'b0;
   logic [1:0]        det_en = 2'h0;
   logic [1:0]        stop_ext = 2'h0;
   logic              tx_end = 1'b0;
   logic [5:0]        tx_err = 6'h00;
   logic              tx_sfd = 1'b0;
   logic              tx_ts_request = 1'b0;
   logic              rx_end;
   logic [47:0]       rx_dest;
   logic [47:0]       rx_src;
   logic [15:0]       rx_len;
   logic [9:0]        fl;
   logic              rx_result_valid, rx_pass, rx_da_fail, rx_sa_fail;
   logic              rx_good, rx_count_update, loop_frame;
   logic              loopback_active, power_down, wake_irq, tx_ts_valid;
   logic [31:0]       rx_frame_count, rx_good_count, tx_good_count;
   logic [31:0]       tx_desc_word_two, tx_desc_word_three;
   logic [31:0]       exp_fr = 32'h0, exp_gd = 32'h0, exp_tx = 32'h0;
   logic [63:0]       stamp;
   int                errors = 0;
   int                samples_checked = 0;
   int                cycles = 0;

   always #4 ref_clk = ~ref_clk;

   phy_status_model phy_status_model_i (
      .ref_clk(ref_clk), .rx_end(rx_end), .rx_dest(rx_dest),
      .rx_src(rx_src), .rx_len(rx_len), .rx_flags(fl));

   eth_mac_rx_filter_pmt_mmc eth_mac_rx_filter_pmt_mmc_i (
      .ref_clk(ref_clk), .rst(rst),
      .promiscuous_mode(cfg[11]), .unicast_hash_mode(cfg[10]),
      .multicast_hash_mode(cfg[9]), .dest_filter_invert(cfg[8]),
      .pass_all_multicast(cfg[7]), .broadcast_block(cfg[6]),
      .hash_or_perfect_mode(cfg[5]), .source_filter_invert(cfg[4]),
      .source_filter_discard(cfg[3]), .control_frame_pass(cfg[1:0]),
      .loopback_select(loopback_select), .hash_table(hash_table),
      .station_addr({D3, SA, MA, UA}), .station_en(4'h7),
      .station_is_source(4'h4), .rx_end(rx_end), .rx_dest(rx_dest),
      .rx_src(rx_src), .rx_len(rx_len), .rx_pause(fl[9]),
      .rx_vlan(fl[8]), .rx_type_frame(fl[7]), .rx_crc_err(fl[6]),
      .rx_mii_err(fl[5]), .rx_align_err(fl[4]), .rx_len_err(fl[3]),
      .rx_gigabit(fl[2]), .rx_wake_frame(fl[1]), .rx_magic(fl[0]),
      .power_down_req(power_down_req), .wake_frame_detect_en(det_en[1]),
      .magic_packet_detect_en(det_en[0]), .stop_mode(stop_ext[1]),
      .external_interrupt_line(stop_ext[0]), .tx_end(tx_end),
      .tx_underrun(tx_err[0]), .tx_carrier_lost(tx_err[1]),
      .tx_jabber(tx_err[2]), .tx_late_coll(tx_err[3]),
      .tx_exc_defer(tx_err[4]), .tx_exc_coll(tx_err[5]),
      .tx_sfd(tx_sfd), .tx_ts_request(tx_ts_request),
      .rx_result_valid(rx_result_valid), .rx_pass(rx_pass),
      .rx_da_fail(rx_da_fail), .rx_sa_fail(rx_sa_fail), .rx_good(rx_good),
      .rx_count_update(rx_count_update), .loop_frame(loop_frame),
      .loopback_active(loopback_active), .rx_frame_count(rx_frame_count),
      .rx_good_count(rx_good_count), .tx_good_count(tx_good_count),
      .power_down(power_down), .wake_irq(wake_irq),
      .tx_ts_valid(tx_ts_valid), .tx_desc_word_two(tx_desc_word_two),
      .tx_desc_word_three(tx_desc_word_three));

   // e = {pass, source fail, good}; hash table all hit or all miss
   task automatic fr(input logic [11:0] c, input logic h,
                     input logic [47:0] d, s, input logic [15:0] l,
                     input logic [9:0] f, input logic [2:0] e);
      logic upd;
      cfg = c;
      hash_table = {64{h}};
      upd = e[2] | (l < 16'h0006);
      exp_fr = exp_fr + {31'h0, upd};
      exp_gd = exp_gd + {31'h0, upd & e[0]};
      phy_status_model_i.send(d, s, l, f);
      `check("rx result", {1'b1, e, upd, e[2] & loopback_select},
             {rx_result_valid, rx_pass, rx_sa_fail, rx_good,
              rx_count_update, loop_frame})
   endtask

   // while powered down: frame never forwarded, wake per enables
   task automatic wk(input logic [1:0] en, se, input logic [47:0] d,
                     input logic [9:0] f, input logic w);
      cfg = C0;
      det_en = en;
      stop_ext = se;
      phy_status_model_i.send(d, SA, N, f);
      `check("wake", {~w, w, d != UA, 2'h0},
             {power_down, wake_irq, rx_da_fail, rx_pass, rx_count_update})
   endtask

   task automatic pdn();
      @(posedge ref_clk);
      #1;
      power_down_req = 1'b1;
      @(posedge ref_clk);
      #1;
      power_down_req = 1'b0;
      `check("power_down", 1'b1, power_down)
   endtask

   task automatic sfd(input logic r);
      @(posedge ref_clk);
      #1;
      tx_sfd = 1'b1;
      tx_ts_request = r;
      @(posedge ref_clk);
      #1;
      tx_sfd = 1'b0;
      `check("tx_ts_valid", r, tx_ts_valid)
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   // far above the ~150 cycles needed
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      `check("loopback_active", 1'b0, loopback_active)
      fr(C0, 1'h0, UA, SA, N, F0, 3'h5);
      fr(C0, 1'h0, UO, SA, N, F0, 3'h1);
      fr(C0, 1'h0, UH, SA, N, F0, 3'h1);
      fr(C0, 1'h0, D3, SA, N, F0, 3'h1);
      fr(UHS, 1'h0, UA, SA, N, F0, 3'h1);
      fr(UHS, 1'h1, UO, SA, N, F0, 3'h5);
      fr(UHS | HOP, 1'h0, UA, SA, N, F0, 3'h5);
      fr(UHS | HOP | DINV, 1'h0, UA, SA, N, F0, 3'h1);
      fr(DINV, 1'h0, UO, SA, N, F0, 3'h5);
      fr(C0, 1'h0, MA, SA, N, F0, 3'h5);
      fr(C0, 1'h0, MO, SA, N, F0, 3'h1);
      fr(C0, 1'h0, MA, SA, N, P, 3'h1);
      fr(CF2, 1'h0, MO, SA, N, P, 3'h5);
      fr(CF3, 1'h0, MO, SA, N, P, 3'h1);
      fr(CF3, 1'h0, MA, SA, N, P, 3'h5);
      fr(MHS, 1'h1, MO, SA, N, F0, 3'h5);
      fr(MHS | HOP, 1'h0, MA, SA, N, F0, 3'h5);
      fr(MHS | DINV, 1'h1, MO, SA, N, F0, 3'h1);
      fr(DINV, 1'h0, MA, SA, N, F0, 3'h1);
      fr(AL | DINV, 1'h0, UA, SO, N, F0, 3'h5);
      fr(AM | DINV, 1'h0, MA, SA, N, F0, 3'h5);
      fr(AL, 1'h0, MA, SA, N, P, 3'h5);
      fr(C0, 1'h0, BC, SA, N, F0, 3'h5);
      fr(BBLK, 1'h0, BC, SA, N, F0, 3'h1);
      fr(C0, 1'h0, UA, SO, N, F0, 3'h7);
      fr(SDISC, 1'h0, UA, SO, N, F0, 3'h3);
      fr(SDISC, 1'h0, UA, SA, N, F0, 3'h5);
      fr(SINV | SDISC, 1'h0, UA, SA, N, F0, 3'h7);
      fr(SINV, 1'h0, UA, SO, N, F0, 3'h5);
      fr(C0, 1'h0, UA, SA, 16'h0040, F0, 3'h5);
      fr(C0, 1'h0, UA, SA, 16'h003f, F0, 3'h4);
      fr(C0, 1'h0, UA, SA, N, C, 3'h4);
      fr(C0, 1'h0, UA, SA, N, M, 3'h4);
      fr(C0, 1'h0, UA, SA, N, A, 3'h4);
      fr(C0, 1'h0, UA, SA, N, A | G, 3'h5);
      fr(C0, 1'h0, UA, SA, N, L, 3'h4);
      fr(C0, 1'h0, UA, SA, N, L | T, 3'h5);
      fr(C0, 1'h0, UA, SA, 16'h05ee, F0, 3'h5);
      fr(C0, 1'h0, UA, SA, 16'h05ef, F0, 3'h4);
      fr(C0, 1'h0, UA, SA, 16'h05f2, V, 3'h5);
      fr(C0, 1'h0, UA, SA, 16'h05f3, V, 3'h4);
      fr(C0, 1'h0, UA, SA, 16'h0640, T, 3'h5);
      fr(C0, 1'h0, UO, SA, 16'h0005, F0, 3'h0);
      fr(C0, 1'h0, UO, SA, 16'h0006, F0, 3'h0);
      loopback_select = 1'b1;
      @(posedge ref_clk);
      #1;
      `check("loopback_active", 1'b1, loopback_active)
      fr(C0, 1'h0, UA, SA, N, F0, 3'h5);
      fr(C0, 1'h0, UO, SA, N, F0, 3'h1);
      loopback_select = 1'b0;
      pdn();
      wk(2'h0, 2'h0, UA, F0, 1'b0);
      wk(2'h1, 2'h0, UA, W, 1'b0);
      wk(2'h2, 2'h0, UA, K, 1'b0);
      wk(2'h1, 2'h0, UO, K, 1'b0);
      wk(2'h2, 2'h2, UA, W, 1'b0);
      wk(2'h2, 2'h3, UA, W, 1'b1);
      pdn();
      wk(2'h1, 2'h0, MO, K, 1'b1);
      `check("rx_frame_count", exp_fr, rx_frame_count)
      `check("rx_good_count", exp_gd, rx_good_count)
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         #1;
         tx_end = 1'b1;
         tx_err = (i == 0) ? 6'h00 : 6'h01 << (i - 1);
         exp_tx = exp_tx + ((i == 0) ? 32'h1 : 32'h0);
         @(posedge ref_clk);
         #1;
         tx_end = 1'b0;
         `check("tx_good_count", exp_tx, tx_good_count)
      end
      sfd(1'b1);
      stamp = {tx_desc_word_three, tx_desc_word_two};
      `check("stamp high", 32'h0, tx_desc_word_three)
      repeat (9) @(posedge ref_clk);
      sfd(1'b0);
      `check("stamp held", stamp,
             {tx_desc_word_three, tx_desc_word_two})
      sfd(1'b1);
      `check("stamp step", stamp + 64'h68,
             {tx_desc_word_three, tx_desc_word_two})
      test_done();
   end
endmodule
